// ---- logic/ext_mem_cfg.svh ----
// constants of the external data memory interface
`ifndef EXT_MEM_CFG_SVH
`define EXT_MEM_CFG_SVH

// address-map modes
`define MAP_INT      2'h0
`define MAP_SPLIT    2'h1
`define MAP_BANK     2'h2
`define MAP_EXT      2'h3

// on-chip xram
`define XRAM_LIMIT   16'h2000
`define XRAM_AW      13
`define XRAM_DEPTH   8192

// reset values: setup and hold at their maximum delay
`define SETUP_RST    2'h3
`define STROBE_RST   4'hF
`define HOLD_RST     2'h3
`define MODE_RST     2'h0
`define MUX_RST      1'h0
`define ALE_RST      2'h3

// counter loads
`define CNT_ZERO     4'h0
`define CNT_ONE      4'h1
`define TAIL_LOAD    4'h2

`endif

// ---- logic/ext_mem_pkg.sv ----
// types of the external data memory interface
package ext_mem_pkg;

  typedef enum logic [8:0] {
    ST_IDLE   = 9'h001,
    ST_XRAM   = 9'h002,
    ST_LEAD   = 9'h004,
    ST_ALE_HI = 9'h008,
    ST_ALE_LO = 9'h010,
    ST_SETUP  = 9'h020,
    ST_STROBE = 9'h040,
    ST_HOLD   = 9'h080,
    ST_TAIL   = 9'h100
  } bus_state_type;

  typedef struct packed {
    logic [1:0] map_mode;
    logic       mux_mode_bit;
    logic [1:0] latch_pulse_width;
  } mem_cfg_type;

  typedef struct packed {
    logic [1:0] setup;
    logic [3:0] strobe;
    logic [1:0] hold;
  } mem_timing_type;

  typedef struct packed {
    logic [15:0] eff_addr;
    logic        off_chip;
    logic        drive_hi;
  } route_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        we;
    logic        wide;
  } cpu_req_type;

  typedef struct packed {
    bus_state_type  st;
    logic [3:0]     cnt;
    cpu_req_type    req;
    logic           drive_hi;
    logic [7:0]     rdata;
    logic           done;
    logic           cap_d1;
    logic           cap_d2;
    logic [7:0]     din_s1;
    logic [7:0]     din_s2;
    mem_cfg_type    cfg;
    mem_timing_type tim;
    logic           rd_n;
    logic           wr_n;
    logic           ale;
    logic           hi_oe;
    logic           lo_oe;
    logic           ad_oe;
    logic [7:0]     ad_out;
  } emi_state_type;

endpackage

// ---- logic/addr_router.sv ----
// address routing between on-chip xram and the off-chip bus
`timescale 1ns/100ps
`default_nettype none
`include "ext_mem_cfg.svh"

module addr_router
  import ext_mem_pkg::*;
(
  input  wire logic [1:0]  map_mode,
  input  wire logic        wide,
  input  wire logic [15:0] data_pointer_pair,
  input  wire logic [7:0]  xram_page_select,
  input  wire logic [7:0]  index_reg,
  output route_type        route
);

  function automatic route_type route_fn(input logic [1:0] mode, input logic w,
                                         input logic [15:0] dp, input logic [7:0] page,
                                         input logic [7:0] idx);
    route_type r;
    r.eff_addr = w ? dp : {page, idx};
    case (mode)
      `MAP_INT: begin
        r.off_chip = 1'b0;
      end
      `MAP_SPLIT, `MAP_BANK: begin
        r.off_chip = (r.eff_addr >= `XRAM_LIMIT);
      end
      default: begin
        r.off_chip = 1'b1;
      end
    endcase
    // 8-bit moves drive the high byte only with bank select
    r.drive_hi = w || (mode == `MAP_BANK);
    return r;
  endfunction

  always_comb begin
    route = route_fn(map_mode, wide, data_pointer_pair, xram_page_select, index_reg);
  end

endmodule // addr_router
`default_nettype wire

// ---- logic/xram_store.sv ----
// on-chip 8 KB xram with registered read
`timescale 1ns/100ps
`default_nettype none
`include "ext_mem_cfg.svh"

module xram_store (
  input  wire logic                clk,
  input  wire logic                en,
  input  wire logic                we,
  input  wire logic [`XRAM_AW-1:0] addr,
  input  wire logic [7:0]          wdata,
  output logic      [7:0]          rdata
);

  logic [7:0] mem [0:`XRAM_DEPTH-1];

  always_ff @(posedge clk) begin
    if (en) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end

endmodule // xram_store
`default_nettype wire

// ---- logic/ext_data_memory_interface.sv ----
// external data memory interface: xram or off-chip bus cycles
`timescale 1ns/100ps
`default_nettype none
`include "ext_mem_cfg.svh"

module ext_data_memory_interface
  import ext_mem_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           sys_rst,
  // cpu data-move request
  input  wire logic           req,
  input  wire logic           req_we,
  input  wire logic           req_wide,
  input  wire logic [15:0]    data_pointer_pair,
  input  wire logic [7:0]     index_reg_a,
  input  wire logic [7:0]     index_reg_b,
  input  wire logic           index_sel,
  input  wire logic [7:0]     req_wdata,
  output logic      [7:0]     rdata,
  output logic                done,
  output logic                busy,
  // configuration
  input  wire logic [7:0]     xram_page_select,
  input  wire logic           cfg_wr,
  input  wire mem_cfg_type    ext_mem_config,
  input  wire logic           timing_wr,
  input  wire mem_timing_type ext_mem_timing_ctrl,
  output mem_cfg_type         ext_mem_config_q,
  output mem_timing_type      ext_mem_timing_q,
  // external bus pins
  output logic      [7:0]     addr_hi_o,
  output logic                addr_hi_oe_n,
  output logic      [7:0]     addr_lo_o,
  output logic                addr_lo_oe_n,
  output logic      [7:0]     ad_o,
  input  wire logic [7:0]     ad_i,
  output logic                ad_oe_n,
  output logic                rd_n,
  output logic                wr_n,
  output logic                ale
);

  emi_state_type q;
  emi_state_type d;
  route_type     route;
  logic [7:0]    xram_rdata;
  logic          xram_en;
  logic          take;

  // ------------------------------------------------------------
  // routing and on-chip memory
  // ------------------------------------------------------------
  addr_router u_router (
    .map_mode          (q.cfg.map_mode),
    .wide              (req_wide),
    .data_pointer_pair (data_pointer_pair),
    .xram_page_select  (xram_page_select),
    .index_reg         (index_sel ? index_reg_b : index_reg_a),
    .route             (route)
  );

  assign take    = req && (q.st == ST_IDLE);
  assign xram_en = take && !route.off_chip;

  xram_store u_xram (
    .clk   (clk),
    .en    (xram_en),
    .we    (req_we),
    .addr  (route.eff_addr[`XRAM_AW-1:0]),
    .wdata (req_wdata),
    .rdata (xram_rdata)
  );

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    d        = q;
    d.done   = 1'b0;
    d.din_s1 = ad_i;
    d.din_s2 = q.din_s1;
    // sample two cycles after the last strobe cycle, past the synchroniser
    d.cap_d1 = (q.st == ST_STROBE) && (q.cnt == `CNT_ZERO) && !q.req.we;
    d.cap_d2 = q.cap_d1;
    if (q.cap_d2) begin
      d.rdata = q.din_s2;
    end
    if (cfg_wr) begin
      d.cfg = ext_mem_config;
    end
    if (timing_wr) begin
      d.tim = ext_mem_timing_ctrl;
    end
    case (q.st)
      ST_IDLE: begin
        if (req) begin
          d.req.addr = route.eff_addr;
          d.req.data = req_wdata;
          d.req.we   = req_we;
          d.req.wide = req_wide;
          d.drive_hi = route.drive_hi;
          d.st       = route.off_chip ? ST_LEAD : ST_XRAM;
        end
      end
      ST_XRAM: begin
        if (!q.req.we) begin
          d.rdata = xram_rdata;
        end
        d.done = 1'b1;
        d.st   = ST_IDLE;
      end
      ST_LEAD: begin
        if (!q.cfg.mux_mode_bit) begin
          d.st  = ST_ALE_HI;
          d.cnt = 4'(q.cfg.latch_pulse_width);
        end else if (q.tim.setup == 2'h0) begin
          d.st  = ST_STROBE;
          d.cnt = q.tim.strobe;
        end else begin
          d.st  = ST_SETUP;
          d.cnt = 4'(q.tim.setup) - `CNT_ONE;
        end
      end
      ST_ALE_HI: begin
        if (q.cnt == `CNT_ZERO) begin
          d.st  = ST_ALE_LO;
          d.cnt = 4'(q.cfg.latch_pulse_width);
        end else begin
          d.cnt = q.cnt - `CNT_ONE;
        end
      end
      ST_ALE_LO: begin
        if (q.cnt != `CNT_ZERO) begin
          d.cnt = q.cnt - `CNT_ONE;
        end else if (q.tim.setup == 2'h0) begin
          d.st  = ST_STROBE;
          d.cnt = q.tim.strobe;
        end else begin
          d.st  = ST_SETUP;
          d.cnt = 4'(q.tim.setup) - `CNT_ONE;
        end
      end
      ST_SETUP: begin
        if (q.cnt == `CNT_ZERO) begin
          d.st  = ST_STROBE;
          d.cnt = q.tim.strobe;
        end else begin
          d.cnt = q.cnt - `CNT_ONE;
        end
      end
      ST_STROBE: begin
        if (q.cnt != `CNT_ZERO) begin
          d.cnt = q.cnt - `CNT_ONE;
        end else if (q.tim.hold == 2'h0) begin
          d.st  = ST_TAIL;
          d.cnt = `TAIL_LOAD;
        end else begin
          d.st  = ST_HOLD;
          d.cnt = 4'(q.tim.hold) - `CNT_ONE;
        end
      end
      ST_HOLD: begin
        if (q.cnt == `CNT_ZERO) begin
          d.st  = ST_TAIL;
          d.cnt = `TAIL_LOAD;
        end else begin
          d.cnt = q.cnt - `CNT_ONE;
        end
      end
      ST_TAIL: begin
        // lead cycle plus three tail cycles make the fixed overhead
        if (q.cnt == `CNT_ZERO) begin
          d.st   = ST_IDLE;
          d.done = 1'b1;
        end else begin
          d.cnt = q.cnt - `CNT_ONE;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    // pins follow the next state so they leave flip-flops
    d.rd_n  = !((d.st == ST_STROBE) && !d.req.we);
    d.wr_n  = !((d.st == ST_STROBE) && d.req.we);
    d.ale   = (d.st == ST_ALE_HI);
    d.hi_oe = (d.st inside {ST_LEAD, ST_ALE_HI, ST_ALE_LO, ST_SETUP, ST_STROBE, ST_HOLD})
              && d.drive_hi;
    d.lo_oe = (d.st inside {ST_LEAD, ST_ALE_HI, ST_ALE_LO, ST_SETUP, ST_STROBE, ST_HOLD})
              && q.cfg.mux_mode_bit;
    if (!q.cfg.mux_mode_bit && (d.st inside {ST_LEAD, ST_ALE_HI, ST_ALE_LO})) begin
      d.ad_oe  = 1'b1;
      d.ad_out = d.req.addr[7:0];
    end else if (d.req.we && (d.st inside {ST_SETUP, ST_STROBE, ST_HOLD})) begin
      d.ad_oe  = 1'b1;
      d.ad_out = d.req.data;
    end else begin
      d.ad_oe  = 1'b0;
      d.ad_out = q.ad_out;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q          <= '0;
      q.st       <= ST_IDLE;
      q.tim      <= {`SETUP_RST, `STROBE_RST, `HOLD_RST};
      q.cfg      <= {`MODE_RST, `MUX_RST, `ALE_RST};
      q.rd_n     <= 1'b1;
      q.wr_n     <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign rdata            = q.rdata;
  assign done             = q.done;
  assign busy             = (q.st != ST_IDLE);
  assign ext_mem_config_q = q.cfg;
  assign ext_mem_timing_q = q.tim;
  assign addr_hi_o        = q.req.addr[15:8];
  assign addr_hi_oe_n     = !q.hi_oe;
  assign addr_lo_o        = q.req.addr[7:0];
  assign addr_lo_oe_n     = !q.lo_oe;
  assign ad_o             = q.ad_out;
  assign ad_oe_n          = !q.ad_oe;
  assign rd_n             = q.rd_n;
  assign wr_n             = q.wr_n;
  assign ale              = q.ale;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  logic min_nonmux;
  logic min_mux;
  assign min_nonmux = take && route.off_chip && q.cfg.mux_mode_bit && (q.tim == '0)
                      && !cfg_wr && !timing_wr;
  assign min_mux    = take && route.off_chip && !q.cfg.mux_mode_bit && (q.tim == '0)
                      && (q.cfg.latch_pulse_width == 2'h0) && !cfg_wr && !timing_wr;

  sequence s_wait5_done;
    (!q.done)[*5] ##1 q.done;
  endsequence
  sequence s_wait7_done;
    (!q.done)[*7] ##1 q.done;
  endsequence
  property p_int_only;
    @(posedge clk) disable iff (sys_rst)
      (take && q.cfg.map_mode == `MAP_INT) |=> (q.st == ST_XRAM) ##1 q.done;
  endproperty
  a_int_only: assert property (p_int_only) else $error("internal mode left xram");
  property p_split_route;
    @(posedge clk) disable iff (sys_rst)
      (take && req_wide && q.cfg.map_mode == `MAP_SPLIT)
        |=> (q.st == (($past(data_pointer_pair) < `XRAM_LIMIT) ? ST_XRAM : ST_LEAD));
  endproperty
  a_split_route: assert property (p_split_route) else $error("split routing wrong");
  property p_ext_only;
    @(posedge clk) disable iff (sys_rst)
      (take && q.cfg.map_mode == `MAP_EXT) |=> (q.st == ST_LEAD) && !q.hi_oe == !q.req.wide;
  endproperty
  a_ext_only: assert property (p_ext_only) else $error("external mode not off-chip");
  property p_no_bank_hi;
    @(posedge clk) disable iff (sys_rst)
      (take && !req_wide && route.off_chip && q.cfg.map_mode != `MAP_BANK)
        |=> addr_hi_oe_n throughout (q.st != ST_IDLE)[*3];
  endproperty
  a_no_bank_hi: assert property (p_no_bank_hi) else $error("high address driven");
  property p_bank_hi;
    @(posedge clk) disable iff (sys_rst)
      (!rd_n || !wr_n) && !q.req.wide && q.cfg.map_mode == `MAP_BANK
        |-> !addr_hi_oe_n && (addr_hi_o == xram_page_select);
  endproperty
  a_bank_hi: assert property (p_bank_hi) else $error("bank high byte wrong");
  property p_min_nonmux;
    @(posedge clk) disable iff (sys_rst)
      min_nonmux |=> s_wait5_done;
  endproperty
  a_min_nonmux: assert property (p_min_nonmux) else $error("nonmux access not 5 cycles");
  property p_min_mux;
    @(posedge clk) disable iff (sys_rst)
      min_mux |=> s_wait7_done;
  endproperty
  a_min_mux: assert property (p_min_mux) else $error("mux access not 7 cycles");
  property p_reset_max;
    @(posedge clk) sys_rst |=> (q.tim.setup == `SETUP_RST) && (q.tim.hold == `HOLD_RST);
  endproperty
  a_reset_max: assert property (p_reset_max) else $error("timing not max after reset");
  property p_ale_addr;
    @(posedge clk) disable iff (sys_rst)
      $fell(ale) |-> !ad_oe_n && (ad_o == q.req.addr[7:0]) && rd_n && wr_n;
  endproperty
  a_ale_addr: assert property (p_ale_addr) else $error("address lost at latch fall");
  property p_xram_quiet;
    @(posedge clk) disable iff (sys_rst)
      (q.st == ST_XRAM) |-> rd_n && wr_n && !ale && addr_hi_oe_n && addr_lo_oe_n && ad_oe_n;
  endproperty
  a_xram_quiet: assert property (p_xram_quiet) else $error("pins active on xram access");
  property p_strobe_one;
    @(posedge clk) disable iff (sys_rst)
      ($fell(rd_n) || $fell(wr_n)) && ($past(q.tim.strobe) == 4'h0) && !timing_wr
        |=> rd_n && wr_n;
  endproperty
  a_strobe_one: assert property (p_strobe_one) else $error("strobe wider than one");

endmodule // ext_data_memory_interface
`default_nettype wire

// ---- test/ext_sram_model.sv ----
// behavioural external parallel memory sitting on the bus pins
`timescale 1ns/100ps
`default_nettype none

module ext_sram_model (
  input  wire logic        clk,
  input  wire logic        non_mux,
  input  wire logic [7:0]  port_hi,
  input  wire logic [7:0]  addr_hi_o,
  input  wire logic        addr_hi_oe_n,
  input  wire logic [7:0]  addr_lo_o,
  input  wire logic        addr_lo_oe_n,
  input  wire logic [7:0]  ad_o,
  input  wire logic        ad_oe_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        ale,
  output logic      [7:0]  ad_i,
  output logic      [15:0] wr_addr,
  output logic      [7:0]  str_len,
  output logic      [7:0]  ale_len
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  lat_q   = 8'h00;
  logic [7:0]  last_q  = 8'h00;
  logic [7:0]  str_cnt = 8'h00;
  logic [7:0]  ale_cnt = 8'h00;
  logic [15:0] a;
  logic [7:0]  ad_w;
  // ----------------------------------------------------------------
  // pin levels
  // ----------------------------------------------------------------
  assign ad_w     = ad_oe_n ? ~last_q : ad_o;
  assign a[15:8]  = addr_hi_oe_n ? port_hi : addr_hi_o;
  assign a[7:0]   = non_mux ? (addr_lo_oe_n ? ~addr_lo_o : addr_lo_o) : lat_q;
  assign ad_i     = !ad_oe_n ? ad_o : (!rd_n ? mem[a] : ~last_q);
  // ----------------------------------------------------------------
  // latch, storage and pulse widths
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    last_q <= ad_i;
    if (ale) lat_q <= ad_w;
    if (!wr_n) begin
      mem[a]  <= ad_w;
      wr_addr <= a;
    end
    if (!rd_n || !wr_n) str_cnt <= str_cnt + 8'h01;
    else if (str_cnt != 8'h00) begin
      str_len <= str_cnt;
      str_cnt <= 8'h00;
    end
    if (ale) ale_cnt <= ale_cnt + 8'h01;
    else if (ale_cnt != 8'h00) begin
      ale_len <= ale_cnt;
      ale_cnt <= 8'h00;
    end
  end
endmodule  // ext_sram_model
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench of the external data memory interface
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module tb;
  import ext_mem_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, req = 1'b0, req_we = 1'b0, req_wide = 1'b0;
  logic index_sel = 1'b0, cfg_wr = 1'b0, timing_wr = 1'b0, mon = 1'b0, ext_seen = 1'b0;
  logic [15:0] data_pointer_pair = 16'h0000;
  logic [7:0] index_reg_a = 8'h00, index_reg_b = 8'h00, req_wdata = 8'h00;
  logic [7:0] xram_page_select = 8'h00, port_hi = 8'h9A;
  mem_cfg_type ext_mem_config = '0;
  mem_timing_type ext_mem_timing_ctrl = '0;
  mem_cfg_type cfg_q;
  mem_timing_type tim_q;
  logic [7:0] rdata, addr_hi_o, addr_lo_o, ad_o, ad_i, str_len, ale_len;
  logic done, busy, addr_hi_oe_n, addr_lo_oe_n, ad_oe_n, rd_n, wr_n, ale;
  logic [15:0] wr_addr;
  int checks = 0, mismatches = 0, exp_n = 0, acc_n = 0;
  localparam logic [10:0] TSET [0:4] = '{11'h400, 11'h4FF, 11'h45E, 11'h000, 11'h38D};

  always #20 clk = ~clk;
  always @(posedge clk) if (mon && (!rd_n || !wr_n || ale || !addr_hi_oe_n ||
                                    !addr_lo_oe_n || !ad_oe_n)) ext_seen <= 1'b1;

  ext_data_memory_interface ext_data_memory_interface_i (.clk(clk), .sys_rst(sys_rst),
    .req(req), .req_we(req_we), .req_wide(req_wide), .data_pointer_pair(data_pointer_pair),
    .index_reg_a(index_reg_a), .index_reg_b(index_reg_b), .index_sel(index_sel),
    .req_wdata(req_wdata), .rdata(rdata), .done(done), .busy(busy),
    .xram_page_select(xram_page_select), .cfg_wr(cfg_wr), .ext_mem_config(ext_mem_config),
    .timing_wr(timing_wr), .ext_mem_timing_ctrl(ext_mem_timing_ctrl),
    .ext_mem_config_q(cfg_q), .ext_mem_timing_q(tim_q), .addr_hi_o(addr_hi_o),
    .addr_hi_oe_n(addr_hi_oe_n), .addr_lo_o(addr_lo_o), .addr_lo_oe_n(addr_lo_oe_n),
    .ad_o(ad_o), .ad_i(ad_i), .ad_oe_n(ad_oe_n), .rd_n(rd_n), .wr_n(wr_n), .ale(ale));

  ext_sram_model ext_sram_model_i (.clk(clk), .non_mux(cfg_q.mux_mode_bit),
    .port_hi(port_hi), .addr_hi_o(addr_hi_o), .addr_hi_oe_n(addr_hi_oe_n),
    .addr_lo_o(addr_lo_o), .addr_lo_oe_n(addr_lo_oe_n), .ad_o(ad_o), .ad_oe_n(ad_oe_n),
    .rd_n(rd_n), .wr_n(wr_n), .ale(ale), .ad_i(ad_i), .wr_addr(wr_addr),
    .str_len(str_len), .ale_len(ale_len));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic acc(input logic we, wide, sel, input logic [15:0] dp,
                     input logic [7:0] idx, wd, output logic [7:0] rd, output int n);
    req_we = we;
    req_wide = wide;
    index_sel = sel;
    index_reg_a = sel ? ~idx : idx;
    index_reg_b = sel ? idx : ~idx;
    data_pointer_pair = dp;
    req_wdata = wd;
    ext_seen = 1'b0;
    mon = 1'b1;
    req = 1'b1;
    @(posedge clk) #1;
    req = 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 200) begin
      @(posedge clk) #1;
      n++;
    end
    mon = 1'b0;
    rd = rdata;
    acc_n = n;
    if (n >= 200) begin
      mismatches++;
      end_sim();
    end
  endtask

  task automatic set_cfg(input logic [1:0] m, input logic x, input logic [1:0] lw, s,
                         input logic [3:0] st, input logic [1:0] h);
    ext_mem_config = {m, x, lw};
    ext_mem_timing_ctrl = {s, st, h};
    cfg_wr = 1'b1;
    timing_wr = 1'b1;
    exp_n = 6 + s + st + h + (x ? 0 : 2 * (lw + 1));
    @(posedge clk) #1;
    cfg_wr = 1'b0;
    timing_wr = 1'b0;
    `CHK("cfg_q", {m, x, lw}, cfg_q)
    `CHK("tim_q", {s, st, h}, tim_q)
  endtask

  // write then read back on chip, through the same or an alias address
  task automatic on_rw(input logic ww, input logic [15:0] wdp, input logic [7:0] widx,
                       input logic [15:0] rdp, input logic [7:0] d);
    logic [7:0] rd;
    int n;
    acc(1'b1, ww, 1'b1, wdp, widx, d, rd, n);
    `CHK("on_ext", 1'b0, ext_seen)
    `CHK("on_cyc", 2, n)
    acc(1'b0, 1'b1, 1'b0, rdp, 8'h00, 8'h00, rd, n);
    `CHK("on_ext", 1'b0, ext_seen)
    `CHK("on_rd", d, rd)
  endtask

  // write then read back off chip, checking the address seen on the pins
  task automatic off_rw(input logic wide, sel, input logic [15:0] dp,
                        input logic [7:0] idx, input logic [15:0] ea);
    logic [7:0] rd;
    int n;
    acc(1'b1, wide, sel, dp, idx, idx ^ 8'h5A, rd, n);
    `CHK("off_ext", 1'b1, ext_seen)
    `CHK("wr_addr", ea, wr_addr)
    `CHK("wr_cyc", exp_n, n)
    acc(1'b0, wide, ~sel, dp, idx, 8'h00, rd, n);
    `CHK("rd_cyc", exp_n, n)
    `CHK("off_rd", idx ^ 8'h5A, rd)
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    #1 sys_rst = 1'b0;
    `CHK("rst_cfg", 5'h03, cfg_q)
    `CHK("rst_tim", 8'hFF, tim_q)
    `CHK("rst_pins", 4'hC, {rd_n, wr_n, ale, busy})
  endtask

  task automatic t_int();
    set_cfg(2'h0, 1'b1, 2'h0, 2'h0, 4'h0, 2'h0);
    on_rw(1'b1, 16'h4005, 8'h00, 16'h0005, 8'hA5);
    xram_page_select = 8'h27;
    on_rw(1'b0, 16'h0000, 8'h10, 16'h0710, 8'h3C);
  endtask

  task automatic t_split();
    set_cfg(2'h1, 1'b1, 2'h0, 2'h0, 4'h0, 2'h0);
    on_rw(1'b1, 16'h1FFF, 8'h00, 16'h1FFF, 8'h96);
    off_rw(1'b1, 1'b0, 16'h2000, 8'h00, 16'h2000);
    `CHK("min_cyc", 6, acc_n)
    xram_page_select = 8'h40;
    off_rw(1'b0, 1'b1, 16'h0000, 8'h22, 16'h9A22);
  endtask

  task automatic t_bank();
    set_cfg(2'h2, 1'b1, 2'h0, 2'h1, 4'h2, 2'h1);
    xram_page_select = 8'h50;
    off_rw(1'b0, 1'b0, 16'h0000, 8'h33, 16'h5033);
    off_rw(1'b1, 1'b1, 16'hFFFF, 8'h00, 16'hFFFF);
    xram_page_select = 8'h05;
    on_rw(1'b0, 16'h0000, 8'h61, 16'h0561, 8'h1E);
  endtask

  task automatic t_ext();
    set_cfg(2'h3, 1'b1, 2'h0, 2'h0, 4'h0, 2'h0);
    xram_page_select = 8'h00;
    off_rw(1'b0, 1'b0, 16'h0000, 8'h44, 16'h9A44);
    off_rw(1'b1, 1'b1, 16'h0100, 8'h00, 16'h0100);
  endtask

  task automatic t_timing();
    logic [10:0] t;
    for (int i = 0; i < 5; i++) begin
      t = TSET[i];
      set_cfg(2'h3, t[10], t[9:8], t[7:6], t[5:2], t[1:0]);
      off_rw(1'b1, 1'b0, 16'hA5C3 + 16'(i), 8'h00, 16'hA5C3 + 16'(i));
      `CHK("str_len", 8'(t[5:2]) + 8'h01, str_len)
      if (!t[10]) `CHK("ale_len", 8'(t[9:8]) + 8'h01, ale_len)
    end
  endtask

  initial begin
    t_reset();
    t_int();
    t_split();
    t_bank();
    t_ext();
    t_timing();
    t_reset();
    end_sim();
  end
endmodule  // tb
`default_nettype wire
